// ===== hw/sssp_pkg.sv
// Constants for the synchronous slave serial port: register offsets,
// field positions, reset values and write masks.
// Assumes a Wishbone slave with byte offsets, each register one word.
package sssp_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_GLOBAL_INT = 8'h00; // Global interrupt control.
    localparam logic [7:0] OFS_PER_ENABLE = 8'h04; // Peripheral enable one.
    localparam logic [7:0] OFS_PER_FLAG   = 8'h08; // Peripheral flags one.
    localparam logic [7:0] OFS_RX_STATUS  = 8'h0C; // Receive status and control.
    localparam logic [7:0] OFS_PORTC_DIR  = 8'h10; // Port C direction.
    localparam logic [7:0] OFS_TX_HOLD    = 8'h14; // Transmit holding, write only.
    localparam logic [7:0] OFS_TX_STATUS  = 8'h18; // Transmit status and control.
    localparam logic [7:0] OFS_RX_DATA    = 8'h1C; // Receive data, read only.

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_GLOBAL_IE = 7; // Global interrupt enable.
    localparam int BIT_PERIPH_IE = 6; // Peripheral interrupt enable.
    localparam int BIT_RX_IE     = 5; // Receive interrupt enable.
    localparam int BIT_TX_IE     = 4; // Transmit interrupt enable.
    localparam int BIT_RX_PEND   = 5; // Receive pending flag.
    localparam int BIT_TX_EMPTY  = 4; // Transmit buffer empty flag.
    localparam int BIT_CLK_SRC   = 7; // Clock source select.
    localparam int BIT_TX_NINE   = 6; // Nine bit transmit enable.
    localparam int BIT_TX_EN     = 5; // Transmit enable.
    localparam int BIT_SYNC      = 4; // Clocked mode select.
    localparam int BIT_SR_EMPTY  = 1; // Shift register empty.
    localparam int BIT_TX_NINTH  = 0; // Transmit ninth bit.
    localparam int BIT_PORT_EN   = 7; // Port enable.
    localparam int BIT_RX_NINE   = 6; // Nine bit receive enable.
    localparam int BIT_SINGLE_RX = 5; // Single receive enable.
    localparam int BIT_CONT_RX   = 4; // Continuous receive enable.
    localparam int BIT_OVERRUN   = 1; // Overrun error flag.
    localparam int BIT_RX_NINTH  = 0; // Received ninth bit.

    // ****************************************
    // Reset values, write masks, sizes
    // ****************************************
    localparam logic [7:0] RST_ZERO      = 8'h00; // Cleared registers.
    localparam logic [7:0] RST_TX_STATUS = 8'h02; // Shift register empty.
    localparam logic [7:0] RST_PORTC_DIR = 8'hFF; // All inputs.
    localparam logic [7:0] WM_TX_STATUS  = 8'hF5; // Writable transmit bits.
    localparam logic [7:0] WM_RX_STATUS  = 8'hF8; // Writable receive bits.
    localparam logic [7:0] WM_PER_FLAG   = 8'hCF; // Flags not owned here.
    localparam int         CHAR_BITS     = 8;     // Low data bits.
    localparam int         FIFO_DEPTH    = 2;     // Receive buffer words.

endpackage

// ===== hw/sssp_top.sv
// Synchronous slave serial port: shift logic clocked by an external
// master, receive buffer, transmit holding stage and a Wishbone slave.
// Assumes the clock and data pins arrive asynchronously to clk.
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/100ps

// Operation
// - Transmitter runs only with transmit enabled.
// - Ninth transmit bit taken from its register bit.
// - Holding register write starts a transmission.
// - Continuous receive keeps receiver accepting, except during overrun.
// - Single receive enable only blocks transmit in slave.
// - Complete character moves into receive buffer.
// - Completion sets pending flag and interrupt.
// - Ninth received bit shown for top character.
// - Clearing continuous receive clears overrun.
// - Only slave mode shifts during sleep.
// - Shift registers stepped by external clock only.
// - Sleep reception sets pending flag, wakes.
// - Wake resumes; global enable takes vector.
// - Data changes leading edge, sampled trailing.
// - Clock pin driver always off in slave.
// - Two-word buffer; third word sets overrun.
// - Second word waits; empty flag stays clear.
module sssp_top
    import sssp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH // Receive buffer words, a power of two.
)
(
    input  wire logic        clk,      // System clock, 20 MHz.
    input  wire logic        rst_n,    // Synchronous reset, active low.
    input  wire logic        wb_cyc_i, // Wishbone cycle.
    input  wire logic        wb_stb_i, // Wishbone strobe.
    input  wire logic        wb_we_i,  // Wishbone write enable.
    input  wire logic [7:0]  wb_adr_i, // Wishbone byte address.
    input  wire logic [3:0]  wb_sel_i, // Wishbone byte selects.
    input  wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic      [31:0] wb_dat_o, // Wishbone read data.
    output logic             wb_ack_o, // Wishbone acknowledge.
    input  wire logic        sleep,    // Processor is asleep.
    input  wire logic        ck_in,    // Clock line pin level.
    output logic             ck_out,   // Clock line drive value.
    output logic             ck_oe,    // Clock line drive enable.
    input  wire logic        dt_in,    // Data line pin level.
    output logic             dt_out,   // Data line drive value.
    output logic             dt_oe,    // Data line drive enable.
    output logic             irq,      // Interrupt request to the core.
    output logic             wake      // Wake request to the core.
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // Pointer width.

    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]    gic;          // Global interrupt control.
    logic [7:0]    pie;          // Peripheral enable one.
    logic [7:0]    pir_keep;     // Flags owned by other peripherals.
    logic [7:0]    rx_ctl;       // Receive control bits.
    logic [7:0]    tx_ctl;       // Transmit control bits.
    logic [7:0]    portc_dir;    // Port C direction.
    logic          ck_s1;        // Clock pin, first stage.
    logic          ck_s2;        // Clock pin, second stage.
    logic          ck_s3;        // Clock pin, edge history.
    logic          dt_s1;        // Data pin, first stage.
    logic          dt_s2;        // Data pin, second stage.
    logic [8:0]    thr;          // Transmit holding word.
    logic          thr_full;     // Holding word waiting.
    logic [8:0]    tx_word;      // Transmit shift register.
    logic          tx_busy;      // Shift register in use.
    logic [3:0]    tcnt;         // Transmit bit index.
    logic [3:0]    tnb;          // Bits in current transmit word.
    logic [8:0]    rx_word;      // Receive shift register.
    logic [8:0]    next_rx_word; // Receive shift after this sample.
    logic [3:0]    rcnt;         // Receive bit index.
    logic [8:0]    mem [DEPTH];  // Receive buffer.
    logic [PW-1:0] wp;           // Buffer write pointer.
    logic [PW-1:0] rp;           // Buffer read pointer.
    logic [PW:0]   cnt;          // Buffer fill count.
    logic          overrun;      // Overrun error flag.
    logic          req;          // New bus request this cycle.
    logic          wr_thr;       // Holding register write.
    logic          pop;          // Receive data read.
    logic          push;         // Character completes into buffer.
    logic          lead;         // Leading clock edge seen.
    logic          trail;        // Trailing clock edge seen.
    logic          slave;        // Synchronous slave selected.
    logic          tx_mode;      // Transmit side active.
    logic          rx_mode;      // Receive side active.
    logic          rx_last;      // Final bit of a character.
    logic          rx_pend;      // Receive pending flag.
    logic          tx_empty;     // Transmit buffer empty flag.
    logic          ev;           // Enabled peripheral event.

    // ****************************************
    // Decode of mode and bus request
    // ****************************************
    assign slave   = tx_ctl[BIT_SYNC] & rx_ctl[BIT_PORT_EN] & ~tx_ctl[BIT_CLK_SRC];
    // Either receive bit steers away from transmit; only continuous receives.
    assign tx_mode = slave & ~(rx_ctl[BIT_CONT_RX] | rx_ctl[BIT_SINGLE_RX])
                     & tx_ctl[BIT_TX_EN];
    assign rx_mode = slave & rx_ctl[BIT_CONT_RX];
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_thr  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_TX_HOLD);
    assign pop     = req & ~wb_we_i & (wb_adr_i == OFS_RX_DATA) & (cnt != '0);
    assign rx_last = (rcnt == (rx_ctl[BIT_RX_NINE] ? 4'h8 : 4'h7));
    assign push    = rx_mode & trail & ~overrun & rx_last
                     & ((cnt != DEPTH[PW:0]) | pop);
    assign rx_pend = (cnt != '0);
    assign tx_empty = ~thr_full;
    assign ev      = (rx_pend & pie[BIT_RX_IE]) | (tx_empty & pie[BIT_TX_IE]);
    // Edges come from the second and third stages only.
    assign lead    = ck_s2 & ~ck_s3;
    assign trail   = ~ck_s2 & ck_s3;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Both pins pass two flops before any edge logic reads them.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            dt_s1 <= 1'b0;
            dt_s2 <= 1'b0;
        end
        else
        begin
            ck_s1 <= ck_in;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            dt_s1 <= dt_in;
            dt_s2 <= dt_s1;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    // Software writes land at the request edge; read-only bits are masked.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            gic       <= RST_ZERO;
            pie       <= RST_ZERO;
            pir_keep  <= RST_ZERO;
            rx_ctl    <= RST_ZERO;
            tx_ctl    <= RST_TX_STATUS;
            portc_dir <= RST_PORTC_DIR;
        end
        else if (req && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == OFS_GLOBAL_INT)
            begin
                gic <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == OFS_PER_ENABLE)
            begin
                pie <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == OFS_PER_FLAG)
            begin
                pir_keep <= wb_dat_i[7:0] & WM_PER_FLAG;
            end
            else if (wb_adr_i == OFS_RX_STATUS)
            begin
                rx_ctl <= wb_dat_i[7:0] & WM_RX_STATUS;
            end
            else if (wb_adr_i == OFS_PORTC_DIR)
            begin
                portc_dir <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == OFS_TX_STATUS)
            begin
                tx_ctl <= wb_dat_i[7:0] & WM_TX_STATUS;
            end
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    // The holding word moves to the shift register once it is free; a new
    // write in the same cycle refills the holding stage after the move.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            thr      <= '0;
            thr_full <= 1'b0;
            tx_word  <= '0;
            tx_busy  <= 1'b0;
            tcnt     <= '0;
            tnb      <= 4'h8;
            dt_out   <= 1'b0;
        end
        else
        begin
            if (!tx_mode)
            begin
                // Transmitter off: shifting stops, the holding word stays.
                tx_busy  <= 1'b0;
                tcnt     <= '0;
            end
            else if (!tx_busy && thr_full)
            begin
                // First bit goes out at once, before any clock edge.
                tx_word  <= thr;
                tx_busy  <= 1'b1;
                thr_full <= 1'b0;
                tcnt     <= '0;
                tnb      <= tx_ctl[BIT_TX_NINE] ? 4'h9 : 4'h8;
                dt_out   <= thr[0];
            end
            else if (tx_busy)
            begin
                // Only the external clock steps the shift register.
                if (lead && tcnt != '0)
                begin
                    dt_out <= tx_word[tcnt];
                end
                if (trail)
                begin
                    if (tcnt == tnb - 4'h1)
                    begin
                        tx_busy <= 1'b0;
                    end
                    else
                    begin
                        tcnt <= tcnt + 4'h1;
                    end
                end
            end
            if (wr_thr)
            begin
                thr      <= {tx_ctl[BIT_TX_NINTH], wb_dat_i[7:0]};
                thr_full <= 1'b1;
            end
        end
    end

    // ****************************************
    // Receive path
    // ****************************************
    // A fresh character starts from a cleared shift register.
    always_comb
    begin
        next_rx_word       = (rcnt == '0) ? '0 : rx_word;
        next_rx_word[rcnt] = dt_s2;
    end

    // Samples on the trailing edge; sleep does not stop the slave side.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_word <= '0;
            rcnt    <= '0;
            overrun <= 1'b0;
        end
        else if (!rx_mode)
        begin
            rcnt    <= '0;
            overrun <= 1'b0;
        end
        else if (trail && !overrun)
        begin
            rx_word <= next_rx_word;
            if (rx_last)
            begin
                rcnt <= '0;
                if (!push)
                begin
                    overrun <= 1'b1;
                end
            end
            else
            begin
                rcnt <= rcnt + 4'h1;
            end
        end
    end

    // Buffer keeps stored words on overrun; port disable flushes it.
    always_ff @(posedge clk)
    begin
        if (!rst_n || !rx_ctl[BIT_PORT_EN])
        begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wp] <= next_rx_word;
                wp      <= wp + 1'b1;
            end
            if (pop)
            begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
        end
    end

    // ****************************************
    // Event outputs
    // ****************************************
    // Wake needs the peripheral enable; vectoring also needs the global one.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wake  <= 1'b0;
            irq   <= 1'b0;
            ck_out <= 1'b0;
            ck_oe  <= 1'b0;
            dt_oe  <= 1'b0;
        end
        else
        begin
            wake   <= ev & gic[BIT_PERIPH_IE];
            irq    <= ev & gic[BIT_PERIPH_IE] & gic[BIT_GLOBAL_IE];
            ck_out <= 1'b0;
            ck_oe  <= 1'b0;
            dt_oe  <= tx_mode;
        end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    // One wait state; unmapped offsets answer with zero.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= '0;
            if (!req || wb_we_i)
            begin
                wb_dat_o <= '0;
            end
            else if (wb_adr_i == OFS_GLOBAL_INT)
            begin
                wb_dat_o[7:0] <= gic;
            end
            else if (wb_adr_i == OFS_PER_ENABLE)
            begin
                wb_dat_o[7:0] <= pie;
            end
            else if (wb_adr_i == OFS_PER_FLAG)
            begin
                wb_dat_o[7:0] <= pir_keep | {2'b00, rx_pend, tx_empty, 4'h0};
            end
            else if (wb_adr_i == OFS_RX_STATUS)
            begin
                wb_dat_o[7:0] <= rx_ctl | {6'h00, overrun, mem[rp][8]};
            end
            else if (wb_adr_i == OFS_PORTC_DIR)
            begin
                wb_dat_o[7:0] <= portc_dir;
            end
            else if (wb_adr_i == OFS_TX_STATUS)
            begin
                wb_dat_o[7:0] <= (tx_ctl & ~8'h02) | {6'h00, ~tx_busy, 1'b0};
            end
            else if (wb_adr_i == OFS_RX_DATA)
            begin
                wb_dat_o[7:0] <= mem[rp][7:0];
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_clock_pin_off: assert property (!ck_oe)
        else $error("Clock line driven by the slave.");
    chk_tx_enable_gate: assert property (!tx_mode |=> !dt_oe)
        else $error("Data line driven with transmitter off.");
    chk_write_fills: assert property (wr_thr |=> !tx_empty)
        else $error("Holding write left buffer empty flag set.");
    chk_ninth_capture: assert property (wr_thr |=> thr[8] == $past(tx_ctl[0]))
        else $error("Ninth transmit bit not captured.");
    chk_data_lead_only: assert property
        ($changed(dt_out) && $past(tx_busy) |-> $past(lead))
        else $error("Data changed away from a leading edge.");
    chk_push_pending: assert property (push |=> rx_pend)
        else $error("Completed character left no pending flag.");
    chk_overrun_clear: assert property (!rx_ctl[BIT_CONT_RX] |=> !overrun)
        else $error("Overrun survived receive disable.");
    chk_overrun_block: assert property (overrun && rx_mode |=> $stable(rcnt))
        else $error("Receiver shifted during overrun.");
    chk_buffer_bound: assert property (cnt <= DEPTH[PW:0])
        else $error("Receive buffer over its depth.");
    chk_single_ignored: assert property
        (rx_ctl[BIT_SINGLE_RX] && !rx_ctl[BIT_CONT_RX] |=> rcnt == '0 && !push)
        else $error("Single receive enable started reception.");
    chk_wake_follows: assert property
        (push && pie[BIT_RX_IE] && gic[BIT_PERIPH_IE] && !req |-> ##2 wake)
        else $error("Received character did not wake.");

    cov_char_rx:  cover property (push);
    cov_overrun:  cover property ($rose(overrun));
    cov_tx_load:  cover property ($rose(tx_busy) && thr_full == 1'b0);
    cov_wake:     cover property (sleep && $rose(wake));

endmodule

// ===== testbench/sssp_ext_master.sv
// Model of the external master that clocks the serial port's link.
// Assumes the bench resolves the data line from both drivers.
`timescale 1ns/100ps
module sssp_ext_master
(
    output logic      ck,     // Link clock, idle low.
    output logic      dt_drv, // Level the master puts on the data line.
    input  wire logic dt_wire // Resolved data line level.
);
    // The clock stands still low between frames.
    initial
    begin
        ck = 1'b0;
        dt_drv = 1'b1;
    end

    // Clocks n bits at 400 ns each, out of phase with the system clock.
    task automatic shift(input logic [8:0] d, input int n, output logic [8:0] q);
        q = 9'h000;
        #13;
        for (int i = 0; i < n; i++)
        begin
            ck = 1'b1;
            dt_drv = d[i];
            #200;
            q[i] = dt_wire;
            ck = 1'b0;
            #200;
        end
        // A released line must not keep showing the last bit.
        dt_drv = ~dt_drv;
    endtask
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the synchronous slave serial port.
// Assumes the external master model drives the link pins.
`timescale 1ns/100ps
module tb_top
    import sssp_pkg::*;
;
    logic        clk, rst_n, cyc, stb, we, sleep;    // Bench-driven inputs.
    logic [7:0]  adr;                                // Register address.
    logic [31:0] wdat, rdat, wb_rd;                  // Bus write and read data.
    logic        ack, ck_out, ck_oe, dt_out, dt_oe;  // Design outputs.
    logic        irq, wake, m_ck, m_dt, dt_wire;     // Core and link signals.
    logic [8:0]  q;                                  // Word seen by the master.
    int          mismatches, n_compared, cycles;     // Report counters.

    // The data line follows whoever enables a driver.
    assign dt_wire = dt_oe ? dt_out : m_dt;

    sssp_top u_sssp_top (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_rd),
        .wb_ack_o(ack), .sleep(sleep), .ck_in(m_ck), .ck_out(ck_out), .ck_oe(ck_oe),
        .dt_in(dt_wire), .dt_out(dt_out), .dt_oe(dt_oe), .irq(irq), .wake(wake));
    sssp_ext_master u_sssp_ext_master (.ck(m_ck), .dt_drv(m_dt), .dt_wire(dt_wire));

    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle; holds until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = wb_rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 8'h00);
        chk(rdat, exp, what);
    endtask

    // Polls the flags until a received word is pending.
    task automatic wait_pend();
        rdat = 32'h0;
        for (int i = 0; i < 40 && rdat[BIT_RX_PEND] !== 1'b1; i++)
            wb(1'b0, OFS_PER_FLAG, 8'h00);
    endtask

    task automatic t_reset();
        rd(OFS_TX_STATUS, 32'h02, "tx status reset");
        rd(OFS_PORTC_DIR, 32'hFF, "port dir reset");
        rd(OFS_PER_ENABLE, 32'h00, "enable reset");
        rd(8'h20, 32'h00, "unmapped read");
        chk({ck_oe, ck_out}, 2'b00, "clock driver");
    endtask

    // Nine-bit word with single receive also set.
    task automatic t_rx();
        wb(1'b1, OFS_TX_STATUS, 8'h10);
        wb(1'b1, OFS_RX_STATUS, 8'hF0);
        wb(1'b1, OFS_PER_ENABLE, 8'h20);
        wb(1'b1, OFS_GLOBAL_INT, 8'hC0);
        u_sssp_ext_master.shift(9'h1A5, 9, q);
        wait_pend();
        chk(irq, 1'b1, "rx irq");
        chk(wake, 1'b1, "rx wake");
        rd(OFS_RX_STATUS, 32'hF1, "ninth bit");
        rd(OFS_RX_DATA, 32'hA5, "rx data");
        rd(OFS_PER_FLAG, 32'h10, "pending cleared");
    endtask

    // Three words into a two-word buffer, then recovery.
    task automatic t_ovr();
        wb(1'b1, OFS_RX_STATUS, 8'h90);
        u_sssp_ext_master.shift(9'h011, 8, q);
        u_sssp_ext_master.shift(9'h022, 8, q);
        u_sssp_ext_master.shift(9'h033, 8, q);
        wait_pend();
        rd(OFS_RX_STATUS, 32'h92, "overrun set");
        rd(OFS_RX_DATA, 32'h11, "first kept");
        rd(OFS_RX_DATA, 32'h22, "second kept");
        wb(1'b1, OFS_RX_STATUS, 8'h80);
        rd(OFS_RX_STATUS, 32'h80, "overrun cleared");
        wb(1'b1, OFS_RX_STATUS, 8'hA0);
        u_sssp_ext_master.shift(9'h055, 8, q);
        rd(OFS_PER_FLAG, 32'h10, "single ignored");
        wb(1'b1, OFS_RX_STATUS, 8'h90);
        rd(OFS_PER_FLAG, 32'h10, "nothing pending");
        sleep <= 1'b1;
        u_sssp_ext_master.shift(9'h044, 8, q);
        wait_pend();
        chk(wake, 1'b1, "sleep rx wake");
        rd(OFS_RX_DATA, 32'h44, "resumed");
        sleep <= 1'b0;
    endtask

    // Two nine-bit words written back to back during sleep.
    task automatic t_tx();
        wb(1'b1, OFS_RX_STATUS, 8'h80);
        wb(1'b1, OFS_GLOBAL_INT, 8'h40);
        wb(1'b1, OFS_PER_ENABLE, 8'h10);
        wb(1'b1, OFS_TX_STATUS, 8'h71);
        sleep <= 1'b1;
        wb(1'b1, OFS_TX_HOLD, 8'h3C);
        wb(1'b1, OFS_TX_HOLD, 8'hC3);
        rd(OFS_PER_FLAG, 32'h00, "second waits");
        chk(ck_oe, 1'b0, "clock driver off");
        u_sssp_ext_master.shift(9'h000, 9, q);
        chk(q, 9'h13C, "first word");
        rd(OFS_PER_FLAG, 32'h10, "holding free");
        chk(wake, 1'b1, "tx wake");
        chk(irq, 1'b0, "no vector");
        u_sssp_ext_master.shift(9'h000, 9, q);
        chk(q, 9'h1C3, "second word");
        sleep <= 1'b0;
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cuts a hang short.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        {rst_n, cyc, stb, we, sleep} = 5'h00;
        adr = 8'h00;
        wdat = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rx();
        t_ovr();
        t_tx();
        results();
    end
endmodule
